// ==== verilog/hwm_pkg.sv ====
/*
 Package for the high-voltage wake input monitor: device modes, pull
 selection codes, filter timing and reset values.
 Assumes a 125 MHz system clock and an active low asynchronous reset.
*/
// Overview of operation
// - Both pin edges count as wake signals
// - Interrupt in normal/stop, wake-up in sleep/fail-safe
// - Static sense monitors the pin continuously
// - Cyclic sense evaluates only inside active window
// - Static sense uses a 16 us deglitch filter
// - Crossing starts filter; accept if stable throughout
// - Enable bit gates all wake signalling
// - Accepted event sets sticky pin wake flag
// - Level status shows live pin in static sense
// - Cyclic sense level status holds sampled level
// - Aux pin filtered 16 us, flagged separately
// - Host selects pull-up and pull-down sources
// - Pull codes: none, down, up, automatic
// - Cyclic samples on high-side on-time; change wakes
package hwm_pkg;
  // Device operating modes
  typedef enum logic [2:0] {
    HWM_NORMAL   = 3'h0,
    HWM_STOP     = 3'h1,
    HWM_SLEEP    = 3'h2,
    HWM_FAILSAFE = 3'h3,
    HWM_INIT     = 3'h4
  } hwm_mode_t;
  // Pull selection codes
  localparam logic [1:0] HWM_PULL_NONE = 2'h0;
  localparam logic [1:0] HWM_PULL_DOWN = 2'h1;
  localparam logic [1:0] HWM_PULL_UP = 2'h2;
  localparam logic [1:0] HWM_PULL_AUTO = 2'h3;
  // Filter timing
  localparam int HWM_CLK_MHZ = 125;
  localparam int HWM_FILTER_US = 16;
  localparam int HWM_FILTER_CYC = HWM_FILTER_US * HWM_CLK_MHZ;
  localparam int HWM_CNT_W = 12;
  localparam logic [HWM_CNT_W-1:0] HWM_CNT_RST = 12'h000;
  localparam logic HWM_FLAG_RST = 1'b0;
endpackage : hwm_pkg

// ==== verilog/hwm_edge_filter.sv ====
/*
 Deglitch filter: a level change starts a timer, a change back cancels it,
 and stability for the full interval accepts the new level.
 Assumes a synchronised input on the same clock as the filter.
*/
`timescale 1ns/1ps
module hwm_edge_filter import hwm_pkg::*; #(
  parameter int FILT_CYC = HWM_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rstSync_b,
  input wire logic active,
  input wire logic level,
  output logic filtLevel,
  output logic accept
);
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [HWM_CNT_W-1:0] cnt; // Time since crossing
    logic pend;                // Crossing pending
    logic stable;              // Accepted level
    logic acc;                 // Accept pulse
  } hwm_filt_t;
  hwm_filt_t st, next_st;

  // Filter next-state logic
  always_comb begin
    next_st = st;
    next_st.acc = 1'b0;
    if (!active) begin
      next_st.pend = 1'b0; // Window closed, drop pending
      next_st.cnt = HWM_CNT_RST;
      next_st.stable = level;
    end else if (level == st.stable) begin
      next_st.pend = 1'b0; // Crossed back, discard
      next_st.cnt = HWM_CNT_RST;
    end else if (!st.pend) begin
      next_st.pend = 1'b1; // Crossing starts interval
      next_st.cnt = 12'h001;
    end else if (st.cnt >= FILT_CYC[HWM_CNT_W-1:0] - 12'h001) begin
      next_st.pend = 1'b0; // Stable long enough
      next_st.cnt = HWM_CNT_RST;
      next_st.stable = level;
      next_st.acc = 1'b1; // Either direction accepted
    end else begin
      next_st.cnt = st.cnt + 12'h001;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign filtLevel = st.stable;
  assign accept = st.acc;

  // ********************************
  // Checks
  // ********************************
  property p_short_glitch;
    @(posedge clk) disable iff (!rstSync_b)
    (active && !st.pend && level != st.stable) ##1 (level == st.stable)
      |=> !st.pend;
  endproperty
  a_short_glitch: assert property (p_short_glitch)
    else $error("glitch left pending");
  property p_accept_needs_pend;
    @(posedge clk) disable iff (!rstSync_b)
    accept |-> $past(st.pend);
  endproperty
  a_accept_needs_pend: assert property (p_accept_needs_pend)
    else $error("accept without pending crossing");
  property p_inactive_quiet;
    @(posedge clk) disable iff (!rstSync_b)
    !active |=> !accept;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet)
    else $error("accept outside window");
endmodule : hwm_edge_filter

// ==== verilog/hv_wake_input_monitor.sv ====
/*
 High-voltage wake input monitor: filters the wake pin and the auxiliary
 wake pin, raises interrupt or wake-up, keeps sticky flags and level status,
 and drives pull source enables.
 Assumes asynchronous pins, host control bits stable in the clock domain.
*/
`timescale 1ns/1ps
module hv_wake_input_monitor import hwm_pkg::*; #(
  parameter int FILT_CYC = HWM_FILTER_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hvWakePin,           // Wake pin comparator output
  input wire logic failOrGeneralIoPin,  // Auxiliary pin comparator output
  input wire hwm_mode_t mode,           // Device mode
  input wire logic wakeEnable,          // Wake capability enable
  input wire logic cyclicSense,         // 1: cyclic, 0: static
  input wire logic timedHighSideOutput, // Timer high-side on-time
  input wire logic auxIsWake,           // Aux pin configured as wake
  input wire logic [1:0] pullSelectBits,
  input wire logic pinWakeFlagClr,      // Host clears pin flag
  input wire logic auxWakeFlagClr,      // Host clears aux flag
  output logic pinWakeFlag,
  output logic auxWakeStatus,
  output logic wakeLevelStatus,
  output logic wakeIrq,                 // One-cycle interrupt request
  output logic wakeUp,                  // One-cycle wake-up request
  output logic pullUpEn,
  output logic pullDownEn
);
  // ********************************
  // State
  // ********************************
  typedef struct packed {
    logic [1:0] pinSh;    // Wake pin synchroniser
    logic [1:0] auxSh;    // Aux pin synchroniser
    logic hsPrev;         // High-side window last cycle
    logic sampled;        // Last cyclic sample
    logic sampValid;      // Sample taken since cyclic start
    logic pinFlag;
    logic auxFlag;
    logic lvl;
    logic irq;
    logic wake;
    logic pu;
    logic pd;
  } hwm_top_t;
  hwm_top_t st, next_st;

  logic rstSync_b;
  logic [1:0] rstSh; // Reset release, kept apart: its own raw reset
  logic pinFilt, pinAcc, auxAcc;
  logic pinEvent, auxEvent, anyEvent, activeMode;

  // Reset release synchroniser
  assign rstSync_b = rstSh[1];

  // ********************************
  // Filters
  // ********************************
  // Static filter runs always in static sense
  hwm_edge_filter #(.FILT_CYC(FILT_CYC)) u_pinFilt (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .active(!cyclicSense),
    .level(st.pinSh[1]),
    .filtLevel(pinFilt),
    .accept(pinAcc)
  );
  // Aux pin static filter
  hwm_edge_filter #(.FILT_CYC(FILT_CYC)) u_auxFilt (
    .clk(clk),
    .rstSync_b(rstSync_b),
    .active(auxIsWake),
    .level(st.auxSh[1]),
    .filtLevel(),
    .accept(auxAcc)
  );

  // Cyclic: sample during on-time, change between samples wakes
  logic cycEvent;
  assign cycEvent = cyclicSense && timedHighSideOutput && !st.hsPrev &&
                    st.sampValid && (st.pinSh[1] != st.sampled);
  assign pinEvent = wakeEnable && (pinAcc || cycEvent);
  assign auxEvent = wakeEnable && auxIsWake && auxAcc;
  assign anyEvent = pinEvent || auxEvent;
  assign activeMode = (mode == HWM_NORMAL) || (mode == HWM_STOP);

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.pinSh = {st.pinSh[0], hvWakePin};
    next_st.auxSh = {st.auxSh[0], failOrGeneralIoPin};
    next_st.hsPrev = timedHighSideOutput;
    if (!cyclicSense) begin
      next_st.sampValid = 1'b0; // Restart sampling on re-entry
    end else if (timedHighSideOutput && !st.hsPrev) begin
      next_st.sampled = st.pinSh[1]; // Sample at on-time
      next_st.sampValid = 1'b1;
    end
    // Sticky flags, set beats clear
    next_st.pinFlag = pinEvent || (st.pinFlag && !pinWakeFlagClr);
    next_st.auxFlag = auxEvent || (st.auxFlag && !auxWakeFlagClr);
    // Interrupt in active modes, wake-up in sleep/fail-safe
    next_st.irq = anyEvent && activeMode;
    next_st.wake = anyEvent &&
                   ((mode == HWM_SLEEP) || (mode == HWM_FAILSAFE));
    // Level status
    if (cyclicSense) begin
      next_st.lvl = next_st.sampled; // Held sample
    end else begin
      next_st.lvl = st.pinSh[1]; // Live level
    end
    // Pull source selection
    case (pullSelectBits)
      HWM_PULL_DOWN: begin
        next_st.pu = 1'b0;
        next_st.pd = 1'b1;
      end
      HWM_PULL_UP: begin
        next_st.pu = 1'b1;
        next_st.pd = 1'b0;
      end
      HWM_PULL_AUTO: begin
        next_st.pu = st.pinSh[1]; // Follow detected level
        next_st.pd = !st.pinSh[1];
      end
      default: begin
        next_st.pu = 1'b0; // No source
        next_st.pd = 1'b0;
      end
    endcase
  end

  // Reset shift register runs on raw reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSh <= 2'h0;
    end else begin
      rstSh <= {rstSh[0], 1'b1};
    end
  end

  // Remaining state on synchronised reset
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      st.pinSh <= 2'h0;
      st.auxSh <= 2'h0;
      st.hsPrev <= 1'b0;
      st.sampled <= 1'b0;
      st.sampValid <= 1'b0;
      st.pinFlag <= HWM_FLAG_RST;
      st.auxFlag <= HWM_FLAG_RST;
      st.lvl <= 1'b0;
      st.irq <= 1'b0;
      st.wake <= 1'b0;
      st.pu <= 1'b0;
      st.pd <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign pinWakeFlag = st.pinFlag;
  assign auxWakeStatus = st.auxFlag;
  assign wakeLevelStatus = st.lvl;
  assign wakeIrq = st.irq;
  assign wakeUp = st.wake;
  assign pullUpEn = st.pu;
  assign pullDownEn = st.pd;

  // ********************************
  // Checks
  // ********************************
  property p_flag_set;
    @(posedge clk) disable iff (!rstSync_b)
    pinEvent |=> pinWakeFlag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("pin event did not set flag");
  property p_irq_mode;
    @(posedge clk) disable iff (!rstSync_b)
    anyEvent && activeMode |=> wakeIrq && !wakeUp;
  endproperty
  a_irq_mode: assert property (p_irq_mode)
    else $error("no interrupt in active mode");
  property p_wake_mode;
    @(posedge clk) disable iff (!rstSync_b)
    anyEvent && (mode == HWM_SLEEP) |=> wakeUp && !wakeIrq;
  endproperty
  a_wake_mode: assert property (p_wake_mode)
    else $error("no wake-up in sleep");
  property p_disabled;
    @(posedge clk) disable iff (!rstSync_b)
    !wakeEnable |=> !wakeIrq && !wakeUp;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("wake while disabled");
  property p_live_level;
    @(posedge clk) disable iff (!rstSync_b)
    !cyclicSense |=> wakeLevelStatus == $past(st.pinSh[1]);
  endproperty
  a_live_level: assert property (p_live_level)
    else $error("level status not live");
  property p_held_level;
    @(posedge clk) disable iff (!rstSync_b)
    cyclicSense && $past(cyclicSense) && !timedHighSideOutput
      |=> $stable(wakeLevelStatus);
  endproperty
  a_held_level: assert property (p_held_level)
    else $error("cyclic level changed outside sample");
  property p_pull_auto;
    @(posedge clk) disable iff (!rstSync_b)
    pullSelectBits == HWM_PULL_AUTO |=> pullUpEn != pullDownEn;
  endproperty
  a_pull_auto: assert property (p_pull_auto)
    else $error("auto pull not exclusive");
  property p_pull_none;
    @(posedge clk) disable iff (!rstSync_b)
    pullSelectBits == HWM_PULL_NONE |=> !pullUpEn && !pullDownEn;
  endproperty
  a_pull_none: assert property (p_pull_none)
    else $error("pull active with none");
  property p_aux_flag;
    @(posedge clk) disable iff (!rstSync_b)
    auxEvent |=> auxWakeStatus;
  endproperty
  a_aux_flag: assert property (p_aux_flag)
    else $error("aux event not flagged");
  c_irq: cover property (@(posedge clk) disable iff (!rstSync_b) wakeIrq);
  c_wake: cover property (@(posedge clk) disable iff (!rstSync_b) wakeUp);
  c_cyc: cover property (@(posedge clk) disable iff (!rstSync_b)
    cycEvent);
  c_aux: cover property (@(posedge clk) disable iff (!rstSync_b)
    auxEvent);
endmodule : hv_wake_input_monitor

// ==== tb/hwm_wake_switch.sv ====
/*
 Far-side model: a switch on the wake pin and a push-pull aux driver.
 Assumes the bench sets switch state and levels at the falling edge.
*/
`timescale 1ns/1ps
module hwm_wake_switch (
  input wire logic clk,
  input wire logic closeSw,
  input wire logic swLevel,
  input wire logic auxLevel,
  input wire logic pullUpEn,
  input wire logic pullDownEn,
  output logic hvWakePin,
  output logic failOrGeneralIoPin
);
  // Floating pin never holds a steady value
  logic floatLvl = 1'b0;
  // Inverse of the pin each cycle while undriven
  always @(posedge clk) begin
    floatLvl <= ~hvWakePin;
  end
  // Open switch leaves the pin to the pull sources
  assign hvWakePin = closeSw ? swLevel : pullUpEn ? 1'b1 :
    pullDownEn ? 1'b0 : floatLvl;
  // Aux line is actively driven
  assign failOrGeneralIoPin = auxLevel;
endmodule : hwm_wake_switch

// ==== tb/hv_wake_input_monitor_tb.sv ====
/*
 Self-checking bench for the wake input monitor.
 Assumes a shortened filter of 20 cycles and a 125 MHz clock.
*/
`timescale 1ns/1ps
module hv_wake_input_monitor_tb import hwm_pkg::*; ();
  // ****************
  // Signals
  // ****************
  localparam int FC = 20; // Shortened filter count
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic closeSw = 1'b1, swLevel = 1'b0, auxLevel = 1'b0;
  logic hvWakePin, failOrGeneralIoPin, pullUpEn, pullDownEn;
  hwm_mode_t mode = HWM_NORMAL;
  logic wakeEnable = 1'b1, cyclicSense = 1'b0, hsOut = 1'b0;
  logic auxIsWake = 1'b0, pinClr = 1'b0, auxClr = 1'b0;
  logic [1:0] pullSel = HWM_PULL_NONE;
  logic pinWakeFlag, auxWakeStatus, wakeLevelStatus, wakeIrq, wakeUp;
  int err_total = 0, cmp_count = 0, nIrq, nWake;
  hwm_mode_t mt[4] = '{HWM_STOP, HWM_SLEEP, HWM_FAILSAFE, HWM_INIT};
  // Clock of 8 ns period
  always #4 clk = ~clk;
  // Far side
  hwm_wake_switch u_sw (.clk(clk), .closeSw(closeSw), .swLevel(swLevel),
    .auxLevel(auxLevel), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
    .hvWakePin(hvWakePin), .failOrGeneralIoPin(failOrGeneralIoPin));
  hv_wake_input_monitor #(.FILT_CYC(FC)) u_dut (.clk(clk), .rst_b(rst_b),
    .hvWakePin(hvWakePin), .failOrGeneralIoPin(failOrGeneralIoPin),
    .mode(mode), .wakeEnable(wakeEnable), .cyclicSense(cyclicSense),
    .timedHighSideOutput(hsOut), .auxIsWake(auxIsWake),
    .pullSelectBits(pullSel), .pinWakeFlagClr(pinClr),
    .auxWakeFlagClr(auxClr), .pinWakeFlag(pinWakeFlag),
    .auxWakeStatus(auxWakeStatus), .wakeLevelStatus(wakeLevelStatus),
    .wakeIrq(wakeIrq), .wakeUp(wakeUp), .pullUpEn(pullUpEn),
    .pullDownEn(pullDownEn));
  // ****************
  // Helpers
  // ****************
  task automatic bad(input string m);
    err_total++;
    $display("BAD t=%0t %s", $time, m);
  endtask : bad
  task automatic chk_bit(input logic got, input logic exp, input string m);
    cmp_count++;
    if (got !== exp) bad(m);
  endtask : chk_bit
  task automatic chk_cnt(input int got, input int exp, input string m);
    cmp_count++;
    if (got != exp) bad(m);
  endtask : chk_cnt
  // Count request pulses over n falling edges
  task automatic watch(input int n);
    nIrq = 0;
    nWake = 0;
    repeat (n) begin
      @(negedge clk);
      if (wakeIrq === 1'b1) nIrq++;
      if (wakeUp === 1'b1) nWake++;
    end
  endtask : watch
  task automatic set_pin(input logic v);
    swLevel = v;
    watch(FC + 10);
  endtask : set_pin
  task automatic clr_flags;
    pinClr = 1'b1;
    auxClr = 1'b1;
    @(negedge clk);
    pinClr = 1'b0;
    auxClr = 1'b0;
    @(negedge clk);
  endtask : clr_flags
  // On-time spans the watch, so the request one edge after the rise counts
  task automatic hs_pulse;
    hsOut = 1'b1;
    watch(6);
    hsOut = 1'b0;
    @(negedge clk);
  endtask : hs_pulse
  // ****************
  // Scenarios
  // ****************
  task automatic t_static;
    set_pin(1'b1);
    chk_cnt(nIrq, 1, "rise irq");
    chk_cnt(nWake, 0, "rise wake");
    chk_bit(pinWakeFlag, 1'b1, "flag set");
    chk_bit(wakeLevelStatus, 1'b1, "level high");
    clr_flags();
    chk_bit(pinWakeFlag, 1'b0, "flag clr");
    set_pin(1'b0);
    chk_cnt(nIrq, 1, "fall irq");
    chk_bit(wakeLevelStatus, 1'b0, "level low");
    clr_flags();
    $display("static done");
  endtask : t_static
  task automatic t_glitch;
    // One-cycle spike
    swLevel = 1'b1;
    @(negedge clk);
    set_pin(1'b0);
    chk_cnt(nIrq, 0, "spike irq");
    // Pulse just short of the interval
    swLevel = 1'b1;
    repeat (FC - 4) @(negedge clk);
    set_pin(1'b0);
    chk_cnt(nIrq, 0, "glitch irq");
    chk_bit(pinWakeFlag, 1'b0, "glitch flag");
    // Cancelled crossing, then a fresh one timed from zero
    swLevel = 1'b1;
    repeat (FC / 2) @(negedge clk);
    swLevel = 1'b0;
    repeat (FC / 2) @(negedge clk);
    swLevel = 1'b1;
    repeat (FC - 1) @(negedge clk);
    chk_bit(pinWakeFlag, 1'b0, "early accept");
    watch(10);
    chk_cnt(nIrq, 1, "restart irq");
    clr_flags();
    $display("glitch done");
  endtask : t_glitch
  task automatic t_modes;
    foreach (mt[i]) begin
      mode = mt[i];
      set_pin(~swLevel);
      chk_cnt(nIrq, int'(mt[i] == HWM_STOP), "mode irq");
      chk_cnt(nWake, int'(mt[i] inside {HWM_SLEEP, HWM_FAILSAFE}),
        "mode wake");
      chk_bit(pinWakeFlag, 1'b1, "mode flag");
      clr_flags();
    end
    mode = HWM_NORMAL;
    wakeEnable = 1'b0;
    set_pin(~swLevel);
    chk_cnt(nIrq + nWake, 0, "disabled req");
    chk_bit(pinWakeFlag, 1'b0, "disabled flag");
    wakeEnable = 1'b1;
    $display("modes done");
  endtask : t_modes
  task automatic t_aux;
    auxIsWake = 1'b1;
    watch(4);
    auxLevel = 1'b1;
    watch(FC + 10);
    chk_bit(auxWakeStatus, 1'b1, "aux flag");
    chk_bit(pinWakeFlag, 1'b0, "aux apart");
    chk_cnt(nIrq, 1, "aux irq");
    clr_flags();
    chk_bit(auxWakeStatus, 1'b0, "aux clr");
    $display("aux done");
  endtask : t_aux
  task automatic t_pull;
    set_pin(1'b0);
    for (int c = 0; c < 4; c++) begin
      pullSel = 2'(c);
      watch(5);
      chk_bit(pullUpEn, c == 2 || (c == 3 && swLevel), "up en");
      chk_bit(pullDownEn, c == 1 || (c == 3 && !swLevel), "dn en");
    end
    pullSel = HWM_PULL_UP;
    watch(5);
    closeSw = 1'b0;
    watch(FC + 10);
    chk_bit(wakeLevelStatus, 1'b1, "pull-up level");
    chk_cnt(nIrq, 1, "pull-up irq");
    swLevel = 1'b1;
    closeSw = 1'b1;
    pullSel = HWM_PULL_NONE;
    clr_flags();
    $display("pull done");
  endtask : t_pull
  task automatic t_cyclic;
    cyclicSense = 1'b1;
    hs_pulse();
    chk_cnt(nIrq, 0, "first sample");
    chk_bit(wakeLevelStatus, 1'b1, "sample level");
    set_pin(1'b0);
    chk_cnt(nIrq + nWake, 0, "outside window");
    chk_bit(wakeLevelStatus, 1'b1, "held sample");
    hs_pulse();
    chk_cnt(nIrq, 1, "sample change");
    chk_bit(wakeLevelStatus, 1'b0, "new sample");
    // Same sensing in sleep gives a wake-up instead
    mode = HWM_SLEEP;
    set_pin(1'b1);
    chk_cnt(nIrq + nWake, 0, "sleep outside");
    hs_pulse();
    chk_cnt(nWake, 1, "sleep sample wake");
    chk_cnt(nIrq, 0, "sleep sample irq");
    chk_bit(wakeLevelStatus, 1'b1, "sleep sample");
    mode = HWM_NORMAL;
    $display("cyclic done");
  endtask : t_cyclic
  // ****************
  // Sequence
  // ****************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // Main test order
  initial begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    watch(4);
    t_static();
    t_glitch();
    t_modes();
    t_aux();
    t_pull();
    t_cyclic();
    complete_run();
  end
  // Hang guard, well past the expected run
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule : hv_wake_input_monitor_tb
